/* hdr_ecc_pkg.sv */
// Shared constants, parity table and carrier types for the header check code
package hdr_ecc_pkg;
  localparam int DATA_W = 24;
  localparam int PAR_W = 6;
  localparam int CHK_W = 8;
  localparam logic [CHK_W-1:0] UNUSED_CHK_MASK = 8'hC0;
  localparam logic [PAR_W-1:0] SYN_ZERO = 6'h00;

  // Parity column of each header data bit, index = data bit position
  localparam logic [PAR_W-1:0] PAR_COL [DATA_W] = '{
    6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h19,
    6'h1A, 6'h1C, 6'h23, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2C,
    6'h31, 6'h32, 6'h34, 6'h38, 6'h1F, 6'h2F, 6'h37, 6'h3B};

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [CHK_W-1:0] chk;
  } header_code_word_type;

  typedef struct packed {
    logic valid;
    header_code_word_type word;
    logic corrected;
    logic uncorrectable;
  } rx_result_type;

  typedef struct packed {
    logic valid;
    header_code_word_type word;
  } tx_result_type;

  // Six parity bits over a header; each bit is the xor of its column members
  function automatic logic [PAR_W-1:0] calc_parity(input logic [DATA_W-1:0] d);
    logic [PAR_W-1:0] p;
    p = SYN_ZERO;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (d[i])
      begin
        p = p ^ PAR_COL[i];
      end
    end
    return p;
  endfunction
endpackage

/* hdr_ecc_decode.sv */
// Combinational syndrome decoder: locates and flips a single bad bit
`timescale 1ns/1ps
`default_nettype none
module hdr_ecc_decode
  import hdr_ecc_pkg::*;
(
  input wire header_code_word_type word_in,
  output header_code_word_type word_out,
  output logic corrected,
  output logic uncorrectable
);
  logic [PAR_W-1:0] syndrome;
  logic [CHK_W-1:0] chk_clean;
  logic hit;

  always_comb
  begin
    chk_clean = word_in.chk & ~UNUSED_CHK_MASK;
    syndrome = calc_parity(word_in.data) ^ chk_clean[PAR_W-1:0];
    word_out.data = word_in.data;
    word_out.chk = chk_clean;
    hit = 1'b0;
    if (syndrome != SYN_ZERO)
    begin
      // Single set bit: only a parity bit was hit
      if ($onehot(syndrome))
      begin
        hit = 1'b1;
        word_out.chk = chk_clean ^ {{(CHK_W-PAR_W){1'b0}}, syndrome};
      end
      for (int i = 0; i < DATA_W; i++)
      begin
        if (syndrome == PAR_COL[i])
        begin
          hit = 1'b1;
          word_out.data[i] = ~word_in.data[i];
        end
      end
    end
    corrected = hit;
    // Unmatched: pass the header untouched, data bits not guessed
    uncorrectable = (syndrome != SYN_ZERO) && !hit;
    if (uncorrectable)
    begin
      word_out.data = word_in.data;
      word_out.chk = chk_clean;
    end
  end
endmodule // hdr_ecc_decode
`default_nettype wire

/* packet_header_secded_ecc.sv */
// Header check-byte generator and checker for link packets
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Host sender appends check code to every header
// - Check code is one byte after header
// - Corrects one flipped bit, detects two
// - Bidirectional peripheral appends same check byte
// - One-way peripheral still repairs single errors
// - Code word is data then parity
// - Syndrome from received data and check bits
// - Zero syndrome passes header unchanged
// - Nonzero syndrome means some bit is wrong
// - Syndrome matching a column locates bad bit
// - One-hot syndrome means parity bit error
// - Six parity bits over 24 data bits
// - Sender drives top two check bits zero
// - Receiver zeroes top two check bits first
// - Each parity bit xors its assigned data bits
module packet_header_secded_ecc
  import hdr_ecc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tx_valid,
  input wire logic [DATA_W-1:0] tx_header,
  output logic tx_out_valid,
  output header_code_word_type tx_word,
  input wire logic rx_valid,
  input wire header_code_word_type rx_word,
  output logic rx_out_valid,
  output header_code_word_type rx_fixed,
  output logic rx_corrected,
  output logic rx_uncorrectable
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    tx_result_type tx;
    rx_result_type rx;
  } state_type;

  state_type state_r;
  state_type state_nxt;
  header_code_word_type dec_word;
  logic dec_corr;
  logic dec_unc;

  hdr_ecc_decode u_decode (
    .word_in(rx_word),
    .word_out(dec_word),
    .corrected(dec_corr),
    .uncorrectable(dec_unc)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.tx.valid = tx_valid;
    if (tx_valid)
    begin
      state_nxt.tx.word.data = tx_header;
      // Only six parity bits exist; top two always zero
      state_nxt.tx.word.chk = {2'b00, calc_parity(tx_header)};
    end
    state_nxt.rx.valid = rx_valid;
    if (rx_valid)
    begin
      state_nxt.rx.word = dec_word;
      state_nxt.rx.corrected = dec_corr;
      state_nxt.rx.uncorrectable = dec_unc;
    end
    else
    begin
      state_nxt.rx.corrected = 1'b0;
      state_nxt.rx.uncorrectable = 1'b0;
    end
    if (reset)
    begin
      state_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    state_r <= state_nxt;
  end

  assign tx_out_valid = state_r.tx.valid;
  assign tx_word = state_r.tx.word;
  assign rx_out_valid = state_r.rx.valid;
  assign rx_fixed = state_r.rx.word;
  assign rx_corrected = state_r.rx.corrected;
  assign rx_uncorrectable = state_r.rx.uncorrectable;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  chk_tx_valid_follow: assert property (tx_valid |=> tx_out_valid)
    else $error("tx valid not forwarded");
  chk_tx_top_zero: assert property (tx_out_valid |-> tx_word.chk[7:6] == 2'b00)
    else $error("tx top check bits not zero");
  chk_tx_data_kept: assert property (tx_valid |=> tx_word.data == $past(tx_header))
    else $error("tx data altered");
  chk_tx_parity_ok: assert property (tx_valid |=> tx_word.chk[5:0] == calc_parity($past(tx_header)))
    else $error("tx parity wrong");
  chk_rx_clean_pass: assert property (rx_valid && rx_word.chk[5:0] == calc_parity(rx_word.data)
      |=> rx_fixed.data == $past(rx_word.data) && !rx_corrected && !rx_uncorrectable)
    else $error("clean header changed");
  chk_rx_flags_excl: assert property (!(rx_corrected && rx_uncorrectable))
    else $error("both flags set");
  chk_rx_fixed_clean: assert property (rx_out_valid && !rx_uncorrectable
      |-> calc_parity(rx_fixed.data) == rx_fixed.chk[5:0])
    else $error("corrected word not a code word");
  chk_rx_top_zero: assert property (rx_out_valid |-> rx_fixed.chk[7:6] == 2'b00)
    else $error("rx top check bits kept");
  chk_rx_unc_pass: assert property (rx_valid ##1 rx_uncorrectable
      |-> rx_fixed.data == $past(rx_word.data))
    else $error("uncorrectable header modified");
  chk_rx_nonzero_flag: assert property (rx_valid && rx_word.chk[5:0] != calc_parity(rx_word.data)
      |=> rx_corrected || rx_uncorrectable)
    else $error("error not flagged");

  cov_tx: cover property (tx_valid ##1 tx_out_valid);
  cov_rx_corr: cover property (rx_corrected);
  cov_rx_unc: cover property (rx_uncorrectable);
  cov_rx_clean: cover property (rx_out_valid && !rx_corrected && !rx_uncorrectable);
endmodule // packet_header_secded_ecc
`default_nettype wire

/* link_peer.sv */
// Far-side link model: loops encoded words back with injected bit flips
`timescale 1ns/1ps
`default_nettype none
module link_peer
  import hdr_ecc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hdr_sent,
  input wire logic [31:0] err_mask,
  input wire logic word_valid,
  input wire header_code_word_type word_in,
  output logic rx_valid,
  output header_code_word_type rx_word
);
  logic [31:0] masks[$];
  always @(posedge clk_sys)
  begin
    if (hdr_sent && !reset)
      masks.push_back(err_mask);
    rx_valid <= word_valid && !reset;
    // Idle line toggles so a stale word is never mistaken for a fresh one
    rx_word <= reset ? '0 : (word_valid ? (word_in ^ masks.pop_front()) : ~rx_word);
  end
endmodule // link_peer
`default_nettype wire

/* tb_packet_header_secded_ecc.sv */
// Self-checking bench for the header check-byte encoder and checker
`timescale 1ns/1ps
`default_nettype none
module tb_packet_header_secded_ecc
  import hdr_ecc_pkg::*;
;
  logic clk_sys = 0, reset = 1, tx_valid = 0, tx_out_valid, rx_valid, rx_out_valid;
  logic rx_corrected, rx_uncorrectable;
  logic [DATA_W-1:0] tx_header = '0;
  logic [31:0] err_mask = '0, rnd;
  header_code_word_type tx_word, rx_word, rx_fixed;
  header_code_word_type tx_q[$];
  logic [33:0] rx_q[$];
  int error_cnt = 0, checks_done = 0, cycles = 0, seed = 61;
  always #5 clk_sys = ~clk_sys;
  packet_header_secded_ecc i_packet_header_secded_ecc (.clk_sys(clk_sys), .reset(reset),
    .tx_valid(tx_valid), .tx_header(tx_header), .tx_out_valid(tx_out_valid),
    .tx_word(tx_word), .rx_valid(rx_valid), .rx_word(rx_word), .rx_out_valid(rx_out_valid),
    .rx_fixed(rx_fixed), .rx_corrected(rx_corrected), .rx_uncorrectable(rx_uncorrectable));
  link_peer i_link_peer (.clk_sys(clk_sys), .reset(reset), .hdr_sent(tx_valid),
    .err_mask(err_mask), .word_valid(tx_out_valid), .word_in(tx_word),
    .rx_valid(rx_valid), .rx_word(rx_word));
  function automatic logic [5:0] par(input logic [23:0] d);
    par = 6'h00;
    for (int i = 0; i < DATA_W; i++)
      par = par ^ (d[i] ? PAR_COL[i] : 6'h00);
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Reference codec: systematic word, then decode by column match
  task automatic send(input logic [23:0] h, input logic [31:0] m);
    logic [31:0] w, r;
    logic [5:0] s;
    logic [1:0] f;
    w = {h, 2'b00, par(h)};
    r = w ^ m;
    r[7:6] = 2'b00;
    s = par(r[31:8]) ^ r[5:0];
    f = (s != 6'h00) ? 2'b01 : 2'b00;
    for (int i = 0; i < 30; i++)
      if (s != 6'h00 && s == (i < 24 ? PAR_COL[i] : 6'h01 << (i - 24)))
      begin
        r = r ^ ((i < 24) ? 32'h1 << (i + 8) : 32'h1 << (i - 24));
        f = 2'b10;
      end
    tx_q.push_back(w);
    rx_q.push_back({r, f});
    tx_valid <= 1'b1;
    tx_header <= h;
    err_mask <= m;
    @(posedge clk_sys);
  endtask
  task automatic end_test(input string n);
    tx_valid <= 1'b0;
    repeat (6) @(posedge clk_sys);
    $display("test %s done", n);
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (tx_out_valid === 1'b1)
      check(34'(tx_word), 34'(tx_q.pop_front()));
    if (rx_out_valid === 1'b1)
      check({rx_fixed, rx_corrected, rx_uncorrectable}, rx_q.pop_front());
    else if (!reset)
      check(34'({rx_corrected, rx_uncorrectable}), 34'h0);
    if (cycles > 3000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int k = 0; k < 40; k++)
    begin
      rnd = $random(seed);
      send(rnd[23:0], 32'h0);
    end
    end_test("clean");
    for (int k = 0; k < 32; k++)
    begin
      rnd = $random(seed);
      send(rnd[23:0], 32'h1 << k);
    end
    end_test("single");
    for (int k = 0; k < 60; k++)
    begin
      rnd = $random(seed);
      send(rnd[23:0], (32'h1 << rnd[28:24]) | (32'h1 << rnd[4:0]));
    end
    end_test("double");
    for (int k = 0; k < 30; k++)
    begin
      rnd = $random(seed);
      send(rnd[23:0], $random(seed));
    end
    end_test("noise");
    check(34'(tx_q.size() + rx_q.size()), 34'h0);
    final_report();
  end
endmodule // tb_packet_header_secded_ecc
`default_nettype wire
